//--- serial_flash_status_and_framing_tb.sv
// Self-checking bench driving the block as a serial host.
`timescale 1ns/1ps
module serial_flash_status_and_framing_tb;
    logic clk_sys_i, sys_rst_i, sclk_i, cs_n_i, si_i, wp_n_i, so_o, so_oe_o, eng_start_o, eng_done_i;
    logic eng_suspend_o, eng_resume_o, quad_lane_enable_o, deep_pd_o;
    logic [7:0] eng_op_o;
    logic [23:0] eng_addr_o;
    logic [15:0] status_o, rx;
    int mismatches = 0, n_tests = 0, n_start = 0;
    sfs_status_framing i_sfs_status_framing (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i),
        .cs_n_i(cs_n_i), .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .eng_start_o(eng_start_o),
        .eng_op_o(eng_op_o), .eng_addr_o(eng_addr_o), .eng_done_i(eng_done_i), .eng_suspend_o(eng_suspend_o),
        .eng_resume_o(eng_resume_o), .status_o(status_o), .quad_lane_enable_o(quad_lane_enable_o),
        .deep_pd_o(deep_pd_o));
    sfs_engine_model i_sfs_engine_model (.clk_i(clk_sys_i), .rst_i(sys_rst_i), .start_i(eng_start_o),
        .suspend_i(eng_suspend_o), .resume_i(eng_resume_o), .done_o(eng_done_i));
    // System clock at 50 MHz.
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    // Counting starts here keeps refused commands visible without a port for refusal.
    always @(posedge clk_sys_i) if (eng_start_o === 1'b1) n_start++;
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // One frame, MSB first; the 30 ns link clock only runs inside the frame.
    task automatic frm(input logic [47:0] d, input int nb);
        cs_n_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        #3;
        for (int i = nb - 1; i >= 0; i--) begin
            si_i = d[i];
            #15 sclk_i = 1'b1;
            rx = {rx[14:0], so_o};
            #15 sclk_i = 1'b0;
        end
        cs_n_i = 1'b1;
        repeat (8) @(posedge clk_sys_i);
    endtask
    task automatic idle();
        for (int i = 0; i < 500 && status_o[0] !== 1'b0; i++) @(posedge clk_sys_i);
        chk(status_o & 16'h0001, 16'h0000);
    endtask
    // Status write preceded by the latch command.
    task automatic wrs(input logic [15:0] v);
        frm(48'h06, 8);
        frm({24'h0, 8'h01, v[7:0], v[15:8]}, 24);
        idle();
    endtask
    initial begin
        {sys_rst_i, cs_n_i, wp_n_i, sclk_i, si_i, rx} = {3'h7, 2'h0, 16'h0000};
        repeat (16) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk(status_o, 16'h0000);
        frm(48'h01_3c00, 24);
        chk(status_o, 16'h0000);
        frm(48'h00c, 9);
        chk(status_o, 16'h0000);
        frm(48'h06, 8);
        chk(status_o, 16'h0002);
        frm(48'h04, 8);
        chk(status_o, 16'h0000);
        $display("Latch and refusal test done");
        frm(48'h06, 8);
        frm(48'h01_ff00, 24);
        chk(status_o & 16'h0001, 16'h0001);
        idle();
        chk(status_o, 16'h00fc);
        frm(48'h0500, 16);
        chk(rx, 16'h00fc);
        wp_n_i <= 1'b0;
        wrs(16'h0000);
        chk(status_o & 16'hfffd, 16'h00fc);
        wp_n_i <= 1'b1;
        wrs(16'h0000);
        chk(status_o, 16'h0000);
        $display("Protection mode test done");
        frm(48'h06, 8);
        frm({40'h02_000000_aa, 1'b1}, 41);
        frm({8'h32, 40'h0}, 48);
        chk(16'(n_start), 16'h0000);
        chk(status_o, 16'h0002);
        frm(48'hc7, 8);
        chk(16'(n_start), 16'h0001);
        chk(16'(eng_op_o), 16'h00c7);
        frm(48'h75, 8);
        chk(status_o & 16'h8401, 16'h8000);
        frm(48'h7a, 8);
        chk(status_o & 16'h8400, 16'h0000);
        idle();
        chk(status_o, 16'h0000);
        wrs(16'h0004);
        frm(48'h06, 8);
        frm(48'h60, 8);
        chk(16'(n_start), 16'h0001);
        frm(48'h20_012345, 32);
        chk(eng_addr_o[23:8], 16'h0123);
        idle();
        $display("Engine test done");
        wrs(16'h0804);
        wrs(16'h0004);
        chk(status_o, 16'h0804);
        frm(48'h3500, 16);
        chk(rx, 16'h0008);
        wrs(16'h0104);
        wrs(16'h0000);
        chk(status_o & 16'hfffd, 16'h0904);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        chk(status_o & 16'h07ff, 16'h0000);
        wrs(16'h0380);
        wrs(16'h0000);
        chk(status_o & 16'h07fd, 16'h0380);
        frm(48'hb9, 8);
        chk(16'(deep_pd_o), 16'h0001);
        frm(48'hab, 8);
        chk(16'(deep_pd_o), 16'h0000);
        $display("Lock mode test done");
        print_verdict();
    end
    // Watchdog well beyond the expected run of about 40 us.
    initial begin
        #1ms;
        mismatches++;
        print_verdict();
    end
endmodule // serial_flash_status_and_framing_tb

//--- sfs_engine_model.sv
// Behavioural program and erase engine that answers the framing block.
`timescale 1ns/1ps
module sfs_engine_model #(
    parameter int DONE_CYC = 200
) (
    input  wire logic clk_i,     // System clock.
    input  wire logic rst_i,     // Power-up reset, active high.
    input  wire logic start_i,   // Start pulse from the block.
    input  wire logic suspend_i, // Pause pulse.
    input  wire logic resume_i,  // Resume pulse.
    output logic      done_o     // One-cycle finish pulse.
);
    int   cnt_reg;
    logic run_reg;
    // A paused operation keeps its remaining count, so resume finishes the same job.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= 0;
            run_reg <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                run_reg <= 1'b1;
                cnt_reg <= DONE_CYC;
            end else if (suspend_i) run_reg <= 1'b0;
            else if (resume_i) run_reg <= 1'b1;
            else if (run_reg && cnt_reg == 1) begin
                run_reg <= 1'b0;
                done_o  <= 1'b1;
            end else if (run_reg) cnt_reg <= cnt_reg - 1;
        end
    end
endmodule // sfs_engine_model

//--- sfs_pkg.sv
// Shared constants for the serial flash status word and command framing block.
package sfs_pkg;

    // Command opcodes understood by the framing logic.
    localparam logic [7:0] OP_WREN    = 8'h06;
    localparam logic [7:0] OP_WRDI    = 8'h04;
    localparam logic [7:0] OP_VWREN   = 8'h50;
    localparam logic [7:0] OP_RDSR_LO = 8'h05;
    localparam logic [7:0] OP_RDSR_HI = 8'h35;
    localparam logic [7:0] OP_STATUS_WRITE_CMD    = 8'h01;
    localparam logic [7:0] OP_PP      = 8'h02;
    localparam logic [7:0] OP_QPP     = 8'h32;
    localparam logic [7:0] OP_SE      = 8'h20;
    localparam logic [7:0] OP_BE32    = 8'h52;
    localparam logic [7:0] OP_BE64    = 8'hd8;
    localparam logic [7:0] OP_CE_A    = 8'hc7;
    localparam logic [7:0] OP_CE_B    = 8'h60;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME  = 8'h7a;
    localparam logic [7:0] OP_DPD     = 8'hb9;
    localparam logic [7:0] OP_RDP     = 8'hab;
    localparam logic [7:0] OP_RSTEN   = 8'h66;
    localparam logic [7:0] OP_RST     = 8'h99;
    localparam logic [7:0] OP_SEC_ERS = 8'h44;
    localparam logic [7:0] OP_SEC_PRG = 8'h42;

    // Bit positions inside the 16-bit status word.
    localparam int ST_WIP  = 0;
    localparam int ST_WEL  = 1;
    localparam int ST_BP0  = 2;
    localparam int ST_BP4  = 6;
    localparam int ST_STATUS_LOCK_MODE_LO = 7;
    localparam int ST_STATUS_LOCK_MODE_HI = 8;
    localparam int ST_QE   = 9;
    localparam int ST_PROGRAM_PAUSED_FLAG = 10;
    localparam int ST_LB1  = 11;
    localparam int ST_LB3  = 13;
    localparam int ST_CMP  = 14;
    localparam int ST_ERASE_PAUSED_FLAG = 15;

    // Plain writable bits (guard, lock mode, quad enable, complement) and set-only lock bits.
    localparam logic [15:0] SR_WR_MASK = 16'h43fc;
    localparam logic [15:0] SR_LB_MASK = 16'h3800;
    // Stored configuration after power-up; lock mode always lands at 00.
    localparam logic [15:0] SR_CFG_RST = 16'h0000;

    // Status lock modes.
    localparam logic [1:0] SRP_SOFT = 2'h0;
    localparam logic [1:0] SRP_HW   = 2'h1;
    localparam logic [1:0] SRP_PWR  = 2'h2;
    localparam logic [1:0] SRP_OTP  = 2'h3;

    // Frame lengths in whole bytes, opcode included; BIT_LAST is the last bit index of a byte.
    localparam logic [2:0] NB_STATUS_WRITE_CMD_LO  = 3'h2;
    localparam logic [2:0] NB_STATUS_WRITE_CMD_ALL = 3'h3;
    localparam logic [2:0] NB_ADDR     = 3'h4;
    localparam logic [2:0] NB_DATA     = 3'h5;
    localparam logic [2:0] NB_MAX      = 3'h7;
    localparam logic [2:0] BIT_LAST    = 3'h7;

    // Length of a non-volatile status write busy cycle, in system clocks.
    localparam logic [7:0] SR_WRITE_CYCLES = 8'h10;

endpackage

//--- sfs_status_framing.sv
// Status word, write protection and serial command framing of a serial flash.
//
// What this block does
// R1: Sixteen-bit status word, busy bit 0, latch bit 1.
// R2: Busy bit high during program, erase, non-volatile status write.
// R3: Bit 1 is latch; cleared latch refuses writes.
// R4: Guard bits 6-2 writable unless hardware-locked.
// R5: Whole erase only with guard/complement match.
// R6: Lock mode 00: write needs latch only.
// R7: Lock mode 01, guard pin low: refuse.
// R8: Lock mode 01, guard pin high: latch enables.
// R9: Lock mode 10 blocks until power cycle.
// R10: Lock mode 11 makes status read-only until power-up reset.
// R11: Quad enable bit 9 frees guard pin.
// R12: Lock bits 13-11 set-only, protect security regions.
// R13: Complement bit 14 joins region selection.
// R14: Suspend sets erase or program paused flag.
// R15: Resume and power cycle clear paused flags.
// R16: Bits captured MSB first on rising clock.
// R17: Host sends opcode, then address or data.
// R18: Reads shift out data until deselect.
// R19: Modifying commands need whole-byte frame length.
// R20: Partial byte in program: nothing, latch kept.
// R21: Opcodes for latch, status read and write.
// R22: Quad commands need quad enable set.
// R23: Latch clears on completion, reset, power-up.
// R24: Refused status write changes nothing, no busy.
// R25: Read-only status bits ignore written data.
`timescale 1ns/1ps
module sfs_status_framing (
    input  wire logic        clk_sys_i,          // System clock, 50 MHz.
    input  wire logic        sys_rst_i,          // Power-up reset, async, active high.
    input  wire logic        sclk_i,             // Serial clock from the host.
    input  wire logic        cs_n_i,             // Chip select, active low.
    input  wire logic        si_i,               // Serial data in.
    input  wire logic        wp_n_i,             // Write-guard pin, active low.
    output logic             so_o,               // Serial data out.
    output logic             so_oe_o,            // Serial data out enable.
    output logic             eng_start_o,        // Pulse: start program or erase.
    output logic       [7:0] eng_op_o,           // Opcode of the started operation.
    output logic      [23:0] eng_addr_o,         // Address of the started operation.
    input  wire logic        eng_done_i,         // Pulse: engine finished.
    output logic             eng_suspend_o,      // Pulse: pause the engine.
    output logic             eng_resume_o,       // Pulse: resume the engine.
    output logic      [15:0] status_o,           // Live status word.
    output logic             quad_lane_enable_o, // Guard and pause pins act as data lanes.
    output logic             deep_pd_o           // Deep power-down active.
);

    // Serial clock domain state.
    logic        started_reg, frame_tgl_reg;
    logic [2:0]  bit_mod_reg, byte_cnt_reg;
    logic [6:0]  shift_reg;
    logic [7:0]  opcode_reg, byte1_reg, byte2_reg, byte3_reg, out_byte;

    // System domain state.
    logic [2:0]  sync_q;
    logic        cs_s, wp_s, tgl_s, cs_prev_reg, tgl_seen_reg, frame_end;
    logic [15:0] cfg_reg, snap_reg;
    logic        wel_reg, vol_reg, rst_armed_reg, dpd_reg;
    logic        eng_active_reg, eng_is_erase_reg, sus_erase_reg, sus_prog_reg;
    logic [7:0]  sr_cnt_reg;
    logic        write_in_progress;

    // Decoded frame.
    logic        byte_ok, cmd_ok, wp_eff, sr_locked, ce_allowed, sec_locked;
    logic        wren_go, wrdi_go, vwren_go, status_write_cmd_go, pp_go, erase_go, ce_go, sec_go, eng_go;
    logic        susp_go, resume_go, dpd_go, rdp_go, rst_go;
    logic [15:0] wr_data, cfg_next;

    // Serial clock domain.

    // Deselect clears the frame marker at once, which resets the interface.
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    // Input bits are shifted in MSB first; counters stay put after deselect so that
    // the system side can read a quiet, stable frame.
    always_ff @(posedge sclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bit_mod_reg   <= 3'h0;
            byte_cnt_reg  <= 3'h0;
            shift_reg     <= 7'h00;
            frame_tgl_reg <= 1'b0;
            opcode_reg    <= 8'h00;
            byte1_reg     <= 8'h00;
            byte2_reg     <= 8'h00;
            byte3_reg     <= 8'h00;
        end else if (!started_reg) begin
            bit_mod_reg   <= 3'h1;                                          // [R16]
            byte_cnt_reg  <= 3'h0;
            shift_reg     <= {6'h00, si_i};
            frame_tgl_reg <= ~frame_tgl_reg;
        end else begin
            bit_mod_reg <= bit_mod_reg + 3'h1;
            shift_reg   <= {shift_reg[5:0], si_i};                          // [R16]
            if (bit_mod_reg == sfs_pkg::BIT_LAST) begin
                if (byte_cnt_reg != sfs_pkg::NB_MAX) begin
                    byte_cnt_reg <= byte_cnt_reg + 3'h1;
                end
                case (byte_cnt_reg)
                    3'h0:    opcode_reg <= {shift_reg, si_i};               // [R17]
                    3'h1:    byte1_reg  <= {shift_reg, si_i};
                    3'h2:    byte2_reg  <= {shift_reg, si_i};
                    3'h3:    byte3_reg  <= {shift_reg, si_i};
                    default: byte3_reg  <= byte3_reg;
                endcase
            end
        end
    end

    // The snapshot is frozen while selected, so continuous reads repeat one value.
    assign out_byte = (opcode_reg == sfs_pkg::OP_RDSR_HI) ? snap_reg[15:8] : snap_reg[7:0];

    // Status bytes leave on falling edges so the host samples them on the next rise.
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_o    <= 1'b0;
            so_oe_o <= 1'b0;
        end else if (started_reg && byte_cnt_reg != 3'h0 &&
                     (opcode_reg == sfs_pkg::OP_RDSR_LO || opcode_reg == sfs_pkg::OP_RDSR_HI)) begin
            so_o    <= out_byte[~bit_mod_reg];                              // [R18] [R21]
            so_oe_o <= 1'b1;
        end else begin
            so_o    <= 1'b0;
            so_oe_o <= 1'b0;
        end
    end

    // System clock domain.

    // Pins and the frame toggle cross on two flip-flops each.
    sfs_sync #(
        .W       (3),
        .RST_VAL (3'h3)
    ) u_sync (
        .clk_i (clk_sys_i),
        .rst_i (sys_rst_i),
        .d_i   ({frame_tgl_reg, wp_n_i, cs_n_i}),
        .q_o   (sync_q)
    );

    assign cs_s  = sync_q[0];
    assign wp_s  = sync_q[1];
    assign tgl_s = sync_q[2];

    // A frame ends on deselect only if at least one clock edge arrived in it.
    assign frame_end = cs_s && !cs_prev_reg && (tgl_s != tgl_seen_reg);

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cs_prev_reg  <= 1'b1;
            tgl_seen_reg <= 1'b0;
        end else begin
            cs_prev_reg <= cs_s;
            if (frame_end) begin
                tgl_seen_reg <= tgl_s;
            end
        end
    end

    // Busy covers a status write cycle and any running engine operation.
    assign write_in_progress = (sr_cnt_reg != 8'h00) || eng_active_reg;                   // [R2]

    // Status word assembly: live bits plus stored configuration.
    always_comb begin
        status_o                    = cfg_reg;                              // [R1] [R13]
        status_o[sfs_pkg::ST_WIP]   = write_in_progress;                                  // [R2]
        status_o[sfs_pkg::ST_WEL]   = wel_reg;                              // [R3]
        status_o[sfs_pkg::ST_PROGRAM_PAUSED_FLAG]  = sus_prog_reg;
        status_o[sfs_pkg::ST_ERASE_PAUSED_FLAG]  = sus_erase_reg;
    end

    assign quad_lane_enable_o = cfg_reg[sfs_pkg::ST_QE];
    assign deep_pd_o          = dpd_reg;

    // Protection decode; with quad lanes on, the guard pin is a data lane.
    always_comb begin
        wp_eff     = cfg_reg[sfs_pkg::ST_QE] ? 1'b1 : wp_s;                 // [R11]
        case (cfg_reg[sfs_pkg::ST_STATUS_LOCK_MODE_HI:sfs_pkg::ST_STATUS_LOCK_MODE_LO])
            sfs_pkg::SRP_SOFT: sr_locked = 1'b0;                            // [R6]
            sfs_pkg::SRP_HW:   sr_locked = !wp_eff;                         // [R7] [R8]
            sfs_pkg::SRP_PWR:  sr_locked = 1'b1;                            // [R9]
            sfs_pkg::SRP_OTP:  sr_locked = 1'b1;                            // [R10]
            default:           sr_locked = 1'b1;
        endcase
        ce_allowed = (cfg_reg[sfs_pkg::ST_BP0+2:sfs_pkg::ST_BP0] == 3'h0 && !cfg_reg[sfs_pkg::ST_CMP]) ||
                     (cfg_reg[sfs_pkg::ST_BP0+2:sfs_pkg::ST_BP0] == 3'h7 && cfg_reg[sfs_pkg::ST_CMP]); // [R5]
        // Security region 1..3 sits in address bits 13:12; region 0 is not a region.
        case (byte2_reg[5:4])
            2'h1:    sec_locked = cfg_reg[sfs_pkg::ST_LB1];                 // [R12]
            2'h2:    sec_locked = cfg_reg[sfs_pkg::ST_LB1+1];
            2'h3:    sec_locked = cfg_reg[sfs_pkg::ST_LB3];
            default: sec_locked = 1'b1;
        endcase
    end

    // Frame decode. While busy or powered down only a few commands get through.
    always_comb begin
        byte_ok   = (bit_mod_reg == 3'h0);                                  // [R19] [R20]
        cmd_ok    = frame_end && byte_ok && !write_in_progress && !dpd_reg;
        wren_go   = cmd_ok && opcode_reg == sfs_pkg::OP_WREN;               // [R21]
        wrdi_go   = cmd_ok && opcode_reg == sfs_pkg::OP_WRDI;
        vwren_go  = cmd_ok && opcode_reg == sfs_pkg::OP_VWREN;
        status_write_cmd_go   = cmd_ok && opcode_reg == sfs_pkg::OP_STATUS_WRITE_CMD && wel_reg && !sr_locked &&
                    byte_cnt_reg >= sfs_pkg::NB_STATUS_WRITE_CMD_LO;                    // [R3] [R24]
        pp_go     = cmd_ok && wel_reg && byte_cnt_reg >= sfs_pkg::NB_DATA &&
                    (opcode_reg == sfs_pkg::OP_PP ||
                     (opcode_reg == sfs_pkg::OP_QPP && cfg_reg[sfs_pkg::ST_QE])); // [R22] [R3]
        erase_go  = cmd_ok && wel_reg && byte_cnt_reg >= sfs_pkg::NB_ADDR &&
                    (opcode_reg == sfs_pkg::OP_SE || opcode_reg == sfs_pkg::OP_BE32 ||
                     opcode_reg == sfs_pkg::OP_BE64);
        ce_go     = cmd_ok && wel_reg && ce_allowed &&
                    (opcode_reg == sfs_pkg::OP_CE_A || opcode_reg == sfs_pkg::OP_CE_B); // [R5]
        sec_go    = cmd_ok && wel_reg && !sec_locked &&
                    ((opcode_reg == sfs_pkg::OP_SEC_ERS && byte_cnt_reg >= sfs_pkg::NB_ADDR) ||
                     (opcode_reg == sfs_pkg::OP_SEC_PRG && byte_cnt_reg >= sfs_pkg::NB_DATA)); // [R12]
        eng_go    = pp_go || erase_go || ce_go || sec_go;
        susp_go   = frame_end && !dpd_reg && opcode_reg == sfs_pkg::OP_SUSPEND && eng_active_reg;
        resume_go = frame_end && !dpd_reg && opcode_reg == sfs_pkg::OP_RESUME &&
                    (sus_erase_reg || sus_prog_reg);
        dpd_go    = cmd_ok && opcode_reg == sfs_pkg::OP_DPD;
        rdp_go    = frame_end && opcode_reg == sfs_pkg::OP_RDP;
        rst_go    = frame_end && byte_ok && rst_armed_reg && opcode_reg == sfs_pkg::OP_RST;
    end

    // Write data: one data byte changes only the low half.
    always_comb begin
        if (byte_cnt_reg >= sfs_pkg::NB_STATUS_WRITE_CMD_ALL) begin
            wr_data = {byte2_reg, byte1_reg};
        end else begin
            wr_data = {cfg_reg[15:8], byte1_reg};
        end
        // Busy, latch and paused positions are outside both masks, so writes to them vanish.
        cfg_next = (cfg_reg & ~sfs_pkg::SR_WR_MASK) | (wr_data & sfs_pkg::SR_WR_MASK) |
                   (wr_data & sfs_pkg::SR_LB_MASK);                         // [R25] [R12] [R4]
    end

    // Stored configuration. Reset lands lock mode at 00, which ends a power lock-down.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_reg <= sfs_pkg::SR_CFG_RST;                                 // [R9] [R11] [R12] [R13]
        end else if (status_write_cmd_go) begin
            cfg_reg <= cfg_next;                                            // [R4] [R24]
        end
    end

    // Status write busy cycle; the volatile path skips it.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sr_cnt_reg <= 8'h00;
        end else if (status_write_cmd_go && !vol_reg) begin
            sr_cnt_reg <= sfs_pkg::SR_WRITE_CYCLES;                         // [R2]
        end else if (sr_cnt_reg != 8'h00) begin
            sr_cnt_reg <= sr_cnt_reg - 8'h01;
        end
    end

    // Write latch: cleared at completion, by disable and by reset, set by enable.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wel_reg <= 1'b0;                                                // [R23]
        end else if (wren_go) begin
            wel_reg <= 1'b1;                                                // [R21]
        end else if (wrdi_go || rst_go || (eng_active_reg && eng_done_i) ||
                     (sr_cnt_reg == 8'h01) || (status_write_cmd_go && vol_reg)) begin
            wel_reg <= 1'b0;                                                // [R23]
        end
    end

    // Volatile enable and reset arming only survive until the next frame.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vol_reg       <= 1'b0;
            rst_armed_reg <= 1'b0;
        end else if (frame_end) begin
            vol_reg       <= vwren_go;
            rst_armed_reg <= byte_ok && !write_in_progress && opcode_reg == sfs_pkg::OP_RSTEN;
        end
    end

    // Deep power-down: left by release or by software reset.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dpd_reg <= 1'b0;
        end else if (rdp_go || rst_go) begin
            dpd_reg <= 1'b0;
        end else if (dpd_go) begin
            dpd_reg <= 1'b1;
        end
    end

    // Engine tracking and paused flags. A paused engine is not busy.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            eng_active_reg   <= 1'b0;
            eng_is_erase_reg <= 1'b0;
            sus_erase_reg    <= 1'b0;                                       // [R15]
            sus_prog_reg     <= 1'b0;
        end else if (eng_go) begin
            eng_active_reg   <= 1'b1;
            eng_is_erase_reg <= erase_go || ce_go || (opcode_reg == sfs_pkg::OP_SEC_ERS);
        end else if (susp_go) begin
            eng_active_reg <= 1'b0;
            sus_erase_reg  <= eng_is_erase_reg;                             // [R14]
            sus_prog_reg   <= !eng_is_erase_reg;
        end else if (resume_go) begin
            eng_active_reg <= 1'b1;
            sus_erase_reg  <= 1'b0;                                         // [R15]
            sus_prog_reg   <= 1'b0;
        end else if (eng_done_i) begin
            eng_active_reg <= 1'b0;
        end
    end

    // Engine command outputs; opcode and address hold until the next start.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            eng_start_o   <= 1'b0;
            eng_suspend_o <= 1'b0;
            eng_resume_o  <= 1'b0;
            eng_op_o      <= 8'h00;
            eng_addr_o    <= 24'h000000;
        end else begin
            eng_start_o   <= eng_go;                                        // [R20]
            eng_suspend_o <= susp_go;
            eng_resume_o  <= resume_go;
            if (eng_go) begin
                eng_op_o   <= opcode_reg;
                eng_addr_o <= {byte1_reg, byte2_reg, byte3_reg};
            end
        end
    end

    // Snapshot for the serial side follows the live word only while deselected,
    // so the serial clock never samples a changing value.
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            snap_reg <= 16'h0000;
        end else if (cs_s) begin
            snap_reg <= status_o;
        end
    end

endmodule // sfs_status_framing

//--- sfs_status_framing_assertions.sv
// Port-level checks of the status word and framing block.
`timescale 1ns/1ps
module sfs_status_framing_assertions (
    input wire logic        clk_sys_i,          // System clock.
    input wire logic        sys_rst_i,          // Reset.
    input wire logic        cs_n_i,             // Chip select.
    input wire logic        so_oe_o,            // Data out enable.
    input wire logic        eng_start_o,        // Engine start.
    input wire logic        eng_suspend_o,      // Engine pause.
    input wire logic        eng_resume_o,       // Engine resume.
    input wire logic [15:0] status_o,           // Status word.
    input wire logic        quad_lane_enable_o  // Quad lanes.
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // A start must be followed by a busy, latched device.
    sequence s_started;
        eng_start_o ##1 (status_o[0] && !eng_start_o);
    endsequence
    a_start_busy: assert property (eng_start_o |-> s_started) else $error("start without busy");
    a_start_latch: assert property (eng_start_o |-> status_o[1]) else $error("start without latch");
    a_suspend_pulse: assert property (eng_suspend_o |=> !eng_suspend_o) else $error("long pause pulse");
    a_paused_idle: assert property (status_o[15] || status_o[10] |-> !status_o[0]) else $error("busy when paused");
    a_resume_clears: assert property (eng_resume_o |-> ##[0:3] !(status_o[15] || status_o[10])) else $error("paused kept");
    a_quad_mirror: assert property (quad_lane_enable_o == status_o[9]) else $error("quad flag differs");
    a_lock_setonly: assert property ((~status_o[13:11] & $past(status_o[13:11])) == 3'h0) else $error("lock cleared");
    a_deselect_quiet: assert property (cs_n_i && $past(cs_n_i) |-> !so_oe_o) else $error("drive when idle");
endmodule // sfs_status_framing_assertions
bind sfs_status_framing sfs_status_framing_assertions i_sfs_status_framing_assertions (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i), .so_oe_o(so_oe_o), .eng_start_o(eng_start_o),
    .eng_suspend_o(eng_suspend_o), .eng_resume_o(eng_resume_o), .status_o(status_o),
    .quad_lane_enable_o(quad_lane_enable_o));

//--- sfs_sync.sv
// Two flip-flop synchroniser for pin and cross-domain levels.
`timescale 1ns/1ps
module sfs_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk_i,   // Destination clock.
    input  wire logic         rst_i,   // Asynchronous reset, active high.
    input  wire logic [W-1:0] d_i,     // Asynchronous level in.
    output logic      [W-1:0] q_o      // Synchronised level out.
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= RST_VAL;
            q_o      <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // sfs_sync
